// ==== inc/pwrseq_pkg.sv ====
/*
 * Constants and types for the power-mode and reset sequencer.
 * Assumes a single 125 MHz sequencer clock that never stops, and
 * an internal RC oscillator that ticks at a nominal 4 MHz.
 */
package pwrseq_pkg;

    // Clock rates
    localparam int CLK_HZ        = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int IRC_HZ        = 4_000_000;
    localparam int IRC_DIV       = CLK_HZ / IRC_HZ;
    localparam logic [4:0] IRC_DIV_LAST = 5'(IRC_DIV - 1);

    // Oscillator start-up after power-down, least time, rounded up
    localparam int IRC_START_NS  = 60_000;
    localparam int IRC_START_CYC =
        (IRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Flash start-up span, counted in oscillator ticks
    localparam int FLASH_WAKE_NS    = 100_000;
    localparam int FLASH_WAKE_TICKS =
        (FLASH_WAKE_NS * (IRC_HZ / 1_000_000) + 999) / 1000;

    // Timer widths and reload values
    localparam int TW = 16;
    localparam logic [TW-1:0] RESUME_IRC_LD  = 16'h0004;
    localparam logic [TW-1:0] RESUME_MAIN_LD = 16'h1000;
    localparam logic [TW-1:0] RST_HOLD_LD    = 16'h0010;
    localparam logic [TW-1:0] FLASH_WAKE_LD  = TW'(FLASH_WAKE_TICKS);

    // Debug lock check
    localparam logic [11:0] LOCK_WORD_OFS = 12'h1fc;
    localparam logic [31:0] LOCK_WORD     = 32'h8765_4321;

    // Values after reset
    localparam logic [31:0] RESET_VECTOR  = 32'h0000_0000;
    localparam logic        DEBUG_EN_RST  = 1'b1;

    // Low-power mode chosen by software
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_SLEEP,
        MODE_PDOWN,
        MODE_DPD
    } pmode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RESET,
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_PDOWN,
        ST_DPD,
        ST_IRC_START,
        ST_RESUME
    } state_t;

endpackage

// ==== design/tick_timer.sv ====
/*
 * Down-counter that counts enable ticks after a start pulse and
 * raises a done level when the loaded count has elapsed.
 * Assumes start and tick are synchronous one-cycle pulses.
 */
`timescale 1ns/10ps

module tick_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Control
    input  wire logic         start,
    input  wire logic         tick,
    input  wire logic [W-1:0] load_val,
    // Status
    output logic              done_q
);

    logic [W-1:0] cnt_q;
    logic         busy_q;

    wire last_tick = busy_q && tick && (cnt_q <= W'(1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q  <= load_val;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (last_tick) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
        end else if (busy_q && tick) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    chk_timer_expiry: assert property (@(posedge clk) disable iff (!rst_n)
        last_tick && !start |=> done_q)
        else $error("timer did not expire on its last tick");

    chk_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> !done_q ##0 busy_q)
        else $error("timer did not restart");

endmodule

// ==== design/pwr_mode_seq.sv ====
/*
 * Power-mode and reset sequencer: idle, sleep, power-down and deep
 * power-down entry and wake-up, reset hold and release, brownout
 * response and the debug lock check after reset.
 * Assumes all inputs are synchronous to CLK, MODE_SEL is set before
 * MODE_ENTER, and MAIN_OSC_TICK pulses once per main oscillator cycle.
 */
`timescale 1ns/10ps

// How it works
// - Idle halts execution until reset or interrupt
// - Idle keeps peripheral clocks; interrupts resume
// - Sleep gates clocks, keeps state, freezes pins
// - Sleep disables oscillator output, keeps RTC oscillator
// - Sleep turns PLL off, clears dividers
// - Sleep ends by reset or clockless interrupt
// - Sleep wake waits 4 or 4096 cycles
// - Power-down also powers off oscillator, flash
// - Power-down wake: 60 us, then 4 ticks
// - Flash blocked until 100 us count expires
// - Deep power-down drops regulator; full reset exit
// - Deep power-down wakes on external reset
// - Pin, watchdog, power-on, brownout reset chip
// - Reset held until all release conditions met
// - Release starts fetch at address zero
// - Brownout warning raises interrupt and status
// - Brownout reset level asserts and holds reset
// - Valid checksum and lock word disable debug
// - External interrupts selectable as power-down wake sources
// - PLL off after reset and power-down
// - Oscillator source is RC after reset
module pwr_mode_seq #(
    parameter int IRC_START_CYC = pwrseq_pkg::IRC_START_CYC
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // Reset sources and release conditions
    input  wire logic        RST_PIN_N,
    input  wire logic        WDT_RESET,
    input  wire logic        POR_ACTIVE,
    input  wire logic        BOD_RESET,
    input  wire logic        BOD_WARN,
    input  wire logic        OSC_RUNNING,
    input  wire logic        FLASH_INIT_DONE,
    // Core requests
    input  wire logic [1:0]  MODE_SEL,
    input  wire logic        MODE_ENTER,
    input  wire logic        PLL_ON_REQ,
    input  wire logic        PLL_CONN_REQ,
    input  wire logic        CLK_SRC_WR,
    input  wire logic        CLK_SRC_MAIN_SEL,
    input  wire logic        MAIN_OSC_TICK,
    // Wake-up sources
    input  wire logic        IRQ_PENDING,
    input  wire logic        CLOCKLESS_IRQ,
    input  wire logic [3:0]  EXT_IRQ,
    input  wire logic [3:0]  EXT_WAKE_EN,
    // Debug lock check
    input  wire logic        SEC_CHECK_STB,
    input  wire logic        SEC_CHECKSUM_OK,
    input  wire logic [11:0] SEC_WORD_OFS,
    input  wire logic [31:0] SEC_WORD,
    input  wire logic        FULL_ERASE,
    // Clock and power controls
    output logic             CPU_RUN,
    output logic             CORE_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             IRC_OUT_EN,
    output logic             IRC_POWER,
    output logic             RTC_OSC_ON,
    output logic             PLL_ON,
    output logic             PLL_CONNECT,
    output logic             CPU_DIV_CLR,
    output logic             USB_DIV_CLR,
    output logic             CLK_SRC_MAIN,
    output logic             FLASH_POWER,
    output logic             FLASH_ACCESS_EN,
    output logic             LOGIC_REG_ON,
    output logic             PIN_HOLD,
    // Reset and status
    output logic             CHIP_RESET_N,
    output logic             CPU_START,
    output logic [31:0]      FETCH_ADDR,
    output logic             BOD_IRQ,
    output logic             BOD_STATUS,
    output logic             DEBUG_EN
);

    localparam logic [15:0] IRC_START_LD = 16'(IRC_START_CYC);

    pwrseq_pkg::state_t state_q, state_d;
    pwrseq_pkg::pmode_t mode_sel;

    logic [4:0]  irc_div_q;
    logic        irc_tick_q;
    logic        rst_arm_q, flash_wait_q, sec_win_q, use_main_q;
    logic        rst_done, res_done, irc_done, flash_done;
    logic        cpu_run_q, core_clk_q, periph_q, irc_out_q, irc_pwr_q;
    logic        rtc_on_q, pll_on_q, pll_conn_q, cpu_div_q, usb_div_q;
    logic        clk_main_q, flash_pwr_q, flash_acc_q, reg_on_q;
    logic        pin_hold_q, chip_rst_n_q, cpu_start_q, bod_irq_q;
    logic        bod_stat_q, debug_en_q, flash_rdy_q;
    logic [31:0] fetch_addr_q;

    assign mode_sel = pwrseq_pkg::pmode_t'(MODE_SEL);

    wire rst_src = !RST_PIN_N || WDT_RESET || POR_ACTIVE || BOD_RESET;
    wire rst_release = !rst_src && OSC_RUNNING && rst_done
                       && FLASH_INIT_DONE;
    wire ext_wake = |(EXT_IRQ & EXT_WAKE_EN);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            pwrseq_pkg::ST_RESET: begin
                if (rst_release) begin
                    state_d = pwrseq_pkg::ST_RUN;
                end
            end
            pwrseq_pkg::ST_RUN: begin
                if (MODE_ENTER) begin
                    case (mode_sel)
                        pwrseq_pkg::MODE_IDLE:  state_d = pwrseq_pkg::ST_IDLE;
                        pwrseq_pkg::MODE_SLEEP: state_d = pwrseq_pkg::ST_SLEEP;
                        pwrseq_pkg::MODE_PDOWN: state_d = pwrseq_pkg::ST_PDOWN;
                        pwrseq_pkg::MODE_DPD:   state_d = pwrseq_pkg::ST_DPD;
                        default:                state_d = state_q;
                    endcase
                end
            end
            pwrseq_pkg::ST_IDLE: begin
                if (IRQ_PENDING) begin
                    state_d = pwrseq_pkg::ST_RUN;
                end
            end
            pwrseq_pkg::ST_SLEEP: begin
                if (CLOCKLESS_IRQ) begin
                    state_d = pwrseq_pkg::ST_RESUME;
                end
            end
            pwrseq_pkg::ST_PDOWN: begin
                if (CLOCKLESS_IRQ || ext_wake) begin
                    state_d = pwrseq_pkg::ST_IRC_START;
                end
            end
            pwrseq_pkg::ST_IRC_START: begin
                if (irc_done) begin
                    state_d = pwrseq_pkg::ST_RESUME;
                end
            end
            pwrseq_pkg::ST_RESUME: begin
                if (res_done) begin
                    state_d = pwrseq_pkg::ST_RUN;
                end
            end
            // only a reset leaves deep power-down
            pwrseq_pkg::ST_DPD: state_d = state_q;
            default:            state_d = pwrseq_pkg::ST_RESET;
        endcase
        if (rst_src) begin
            state_d = pwrseq_pkg::ST_RESET;
        end
    end

    wire n_reset = state_d == pwrseq_pkg::ST_RESET;
    wire n_run   = state_d == pwrseq_pkg::ST_RUN;
    wire n_idle  = state_d == pwrseq_pkg::ST_IDLE;
    wire n_sleep = state_d == pwrseq_pkg::ST_SLEEP;
    wire n_pdown = state_d == pwrseq_pkg::ST_PDOWN;
    wire n_dpd   = state_d == pwrseq_pkg::ST_DPD;
    wire n_irc   = state_d == pwrseq_pkg::ST_IRC_START;
    wire n_res   = state_d == pwrseq_pkg::ST_RESUME;
    wire in_run  = state_q == pwrseq_pkg::ST_RUN;
    wire lowpow_entry = in_run && (n_sleep || n_pdown || n_dpd);
    wire pd_entry     = in_run && (n_pdown || n_dpd);

    // Timer launches
    wire res_start   = n_res && state_q != pwrseq_pkg::ST_RESUME;
    wire irc_start   = n_irc && state_q == pwrseq_pkg::ST_PDOWN;
    wire flash_start = n_res && state_q == pwrseq_pkg::ST_IRC_START;
    // main oscillator only when sleep was entered on it
    wire res_main    = use_main_q && state_q == pwrseq_pkg::ST_SLEEP;
    wire res_tick    = use_main_q ? MAIN_OSC_TICK : irc_tick_q;
    wire [15:0] res_ld = res_main ? pwrseq_pkg::RESUME_MAIN_LD
                                  : pwrseq_pkg::RESUME_IRC_LD;

    wire core_clk_d = n_reset || n_run || n_idle;
    wire periph_d   = n_run || n_idle;
    wire pin_hold_d = n_sleep || n_pdown || n_irc || n_res;
    // output off, oscillator kept powered in sleep
    wire irc_out_d  = !(n_sleep || n_pdown || n_dpd || n_irc);
    wire irc_pwr_d  = !(n_pdown || n_dpd);
    wire flash_pwr_d = !(n_pdown || n_dpd || n_irc);
    wire reg_on_d   = !n_dpd;
    // PLL off after reset and low-power entry
    wire pll_on_d   = (n_reset || lowpow_entry) ? 1'b0
                    : (PLL_ON_REQ && n_run) ? 1'b1 : pll_on_q;
    wire pll_conn_d = pll_on_d && (pll_conn_q || (PLL_CONN_REQ && n_run));
    // RC oscillator after reset and power-down
    wire clk_main_d = (n_reset || pd_entry) ? 1'b0
                    : (CLK_SRC_WR && n_run) ? CLK_SRC_MAIN_SEL : clk_main_q;
    // flash ready on reset exit, after its own count on power-down wake
    wire flash_rdy_d = (n_reset || pd_entry) ? !n_reset && 1'b0
                     : (state_q == pwrseq_pkg::ST_RESET) ? 1'b1
                     : (flash_wait_q && flash_done) ? 1'b1 : flash_rdy_q;
    wire flash_acc_d = flash_rdy_d && flash_pwr_d;
    wire cpu_start_d = state_q == pwrseq_pkg::ST_RESET && n_run;
    wire lock_hit = SEC_CHECK_STB && sec_win_q && SEC_CHECKSUM_OK
                    && SEC_WORD_OFS == pwrseq_pkg::LOCK_WORD_OFS
                    && SEC_WORD == pwrseq_pkg::LOCK_WORD;
    wire debug_en_d = FULL_ERASE ? 1'b1 : lock_hit ? 1'b0 : debug_en_q;

    // Divider for the RC oscillator tick
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irc_div_q  <= 5'h00;
            irc_tick_q <= 1'b0;
        end else begin
            irc_tick_q <= irc_pwr_q && irc_div_q == pwrseq_pkg::IRC_DIV_LAST;
            irc_div_q  <= (irc_div_q == pwrseq_pkg::IRC_DIV_LAST)
                          ? 5'h00 : irc_div_q + 5'h01;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q      <= pwrseq_pkg::ST_RESET;
            rst_arm_q    <= 1'b1;
            flash_wait_q <= 1'b0;
            sec_win_q    <= 1'b0;
            use_main_q   <= 1'b0;
        end else begin
            state_q      <= state_d;
            rst_arm_q    <= 1'b0;
            flash_wait_q <= flash_start ||
                            (flash_wait_q && !flash_done && !n_reset);
            sec_win_q    <= cpu_start_d || (sec_win_q && !SEC_CHECK_STB);
            // Power-down wake always resumes on RC oscillator ticks
            use_main_q   <= (lowpow_entry) ? (clk_main_q && !pd_entry)
                                           : use_main_q;
        end
    end

    // Registered outputs
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cpu_run_q    <= 1'b0;
            core_clk_q   <= 1'b1;
            periph_q     <= 1'b0;
            irc_out_q    <= 1'b1;
            irc_pwr_q    <= 1'b1;
            rtc_on_q     <= 1'b1;
            pll_on_q     <= 1'b0;
            pll_conn_q   <= 1'b0;
            cpu_div_q    <= 1'b0;
            usb_div_q    <= 1'b0;
            clk_main_q   <= 1'b0;
            flash_pwr_q  <= 1'b1;
            flash_rdy_q  <= 1'b0;
            flash_acc_q  <= 1'b0;
            reg_on_q     <= 1'b1;
            pin_hold_q   <= 1'b0;
            chip_rst_n_q <= 1'b0;
            cpu_start_q  <= 1'b0;
            fetch_addr_q <= pwrseq_pkg::RESET_VECTOR;
            bod_irq_q    <= 1'b0;
            bod_stat_q   <= 1'b0;
            debug_en_q   <= pwrseq_pkg::DEBUG_EN_RST;
        end else begin
            cpu_run_q    <= n_run;
            core_clk_q   <= core_clk_d;
            periph_q     <= periph_d;
            irc_out_q    <= irc_out_d;
            irc_pwr_q    <= irc_pwr_d;
            rtc_on_q     <= 1'b1;
            pll_on_q     <= pll_on_d;
            pll_conn_q   <= pll_conn_d;
            cpu_div_q    <= lowpow_entry;
            usb_div_q    <= lowpow_entry;
            clk_main_q   <= clk_main_d;
            flash_pwr_q  <= flash_pwr_d;
            flash_rdy_q  <= flash_rdy_d;
            flash_acc_q  <= flash_acc_d;
            reg_on_q     <= reg_on_d;
            pin_hold_q   <= pin_hold_d;
            chip_rst_n_q <= !n_reset;
            cpu_start_q  <= cpu_start_d;
            fetch_addr_q <= pwrseq_pkg::RESET_VECTOR;
            bod_irq_q    <= BOD_WARN;
            bod_stat_q   <= BOD_WARN;
            debug_en_q   <= debug_en_d;
        end
    end

    // reset hold timer restarts while any source is active
    tick_timer #(.W(pwrseq_pkg::TW)) u_rst_tmr (
        .clk      (CLK),
        .rst_n    (RESETN),
        .start    (rst_src || rst_arm_q),
        .tick     (irc_tick_q),
        .load_val (pwrseq_pkg::RST_HOLD_LD),
        .done_q   (rst_done)
    );

    tick_timer #(.W(pwrseq_pkg::TW)) u_res_tmr (
        .clk      (CLK),
        .rst_n    (RESETN),
        .start    (res_start),
        .tick     (res_start ? 1'b0 : res_tick),
        .load_val (res_ld),
        .done_q   (res_done)
    );

    // oscillator start-up, counted in sequencer clocks
    tick_timer #(.W(pwrseq_pkg::TW)) u_irc_tmr (
        .clk      (CLK),
        .rst_n    (RESETN),
        .start    (irc_start),
        .tick     (1'b1),
        .load_val (IRC_START_LD),
        .done_q   (irc_done)
    );

    tick_timer #(.W(pwrseq_pkg::TW)) u_flash_tmr (
        .clk      (CLK),
        .rst_n    (RESETN),
        .start    (flash_start),
        .tick     (irc_tick_q),
        .load_val (pwrseq_pkg::FLASH_WAKE_LD),
        .done_q   (flash_done)
    );

    assign CPU_RUN         = cpu_run_q;
    assign CORE_CLK_EN     = core_clk_q;
    assign PERIPH_CLK_EN   = periph_q;
    assign IRC_OUT_EN      = irc_out_q;
    assign IRC_POWER       = irc_pwr_q;
    assign RTC_OSC_ON      = rtc_on_q;
    assign PLL_ON          = pll_on_q;
    assign PLL_CONNECT     = pll_conn_q;
    assign CPU_DIV_CLR     = cpu_div_q;
    assign USB_DIV_CLR     = usb_div_q;
    assign CLK_SRC_MAIN    = clk_main_q;
    assign FLASH_POWER     = flash_pwr_q;
    assign FLASH_ACCESS_EN = flash_acc_q;
    assign LOGIC_REG_ON    = reg_on_q;
    assign PIN_HOLD        = pin_hold_q;
    assign CHIP_RESET_N    = chip_rst_n_q;
    assign CPU_START       = cpu_start_q;
    assign FETCH_ADDR      = fetch_addr_q;
    assign BOD_IRQ         = bod_irq_q;
    assign BOD_STATUS      = bod_stat_q;
    assign DEBUG_EN        = debug_en_q;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    wire q_idle  = state_q == pwrseq_pkg::ST_IDLE;
    wire q_sleep = state_q == pwrseq_pkg::ST_SLEEP;

    chk_idle_halt: assert property (q_idle |-> !cpu_run_q)
        else $error("core runs in idle");
    chk_idle_wake: assert property (q_idle && IRQ_PENDING && !rst_src
        |=> cpu_run_q && periph_q)
        else $error("idle not left on interrupt");
    chk_sleep_gate: assert property (q_sleep
        |-> !core_clk_q && !periph_q && pin_hold_q && flash_pwr_q)
        else $error("sleep clocks or pins wrong");
    chk_sleep_osc: assert property (q_sleep
        |-> !irc_out_q && irc_pwr_q && rtc_on_q)
        else $error("sleep oscillator state wrong");
    chk_sleep_pll: assert property (in_run && n_sleep
        |=> !pll_on_q && cpu_div_q && usb_div_q)
        else $error("sleep entry left PLL or dividers");
    chk_sleep_resume: assert property (q_sleep && CLOCKLESS_IRQ
        && !rst_src && !use_main_q
        |=> !cpu_run_q [*8] ##[1:160] cpu_run_q)
        else $error("sleep resume delay wrong");
    chk_pdown_power: assert property (state_q == pwrseq_pkg::ST_PDOWN
        |-> !irc_pwr_q && !flash_pwr_q && !flash_acc_q)
        else $error("power-down left oscillator or flash on");
    chk_dpd_reg: assert property (state_q == pwrseq_pkg::ST_DPD
        |-> !reg_on_q)
        else $error("regulator on in deep power-down");
    chk_reset_src: assert property (rst_src |=> !chip_rst_n_q)
        else $error("reset source not obeyed");
    chk_reset_release: assert property ($rose(chip_rst_n_q)
        |-> $past(RST_PIN_N) && $past(OSC_RUNNING)
        && $past(FLASH_INIT_DONE) && cpu_start_q)
        else $error("reset released early");
    chk_bod_irq: assert property (BOD_WARN |=> bod_irq_q && bod_stat_q)
        else $error("brownout warning lost");
    chk_debug_lock: assert property (lock_hit && !FULL_ERASE
        |=> !debug_en_q)
        else $error("debug not locked");
    chk_reset_clock: assert property (!chip_rst_n_q
        |-> !pll_on_q && !clk_main_q)
        else $error("PLL or main clock kept through reset");

    cov_idle_wake:  cover property (q_idle ##1 cpu_run_q);
    cov_sleep_wake: cover property (q_sleep ##1 n_res [*2] ##[1:200] n_run);
    cov_pdown_wake: cover property (flash_wait_q
        ##1 (!flash_wait_q && flash_acc_q));
    cov_dbg_lock:   cover property (lock_hit);

endmodule

// ==== dv/osc_flash_model.sv ====
/* Oscillator and flash controller model beside the sequencer.
   Assumes the sequencer clock runs free and the main osc is stable. */
`timescale 1ns/10ps
module osc_flash_model (
    // Clock and chip reset
    input  wire logic clk,
    input  wire logic chip_reset_n,
    // Oscillator and flash status
    output logic      osc_running,
    output logic      flash_init_done,
    output logic      main_osc_tick
);
    logic [1:0] div_q  = 2'h0;
    logic [5:0] init_q = 6'h00;
    assign osc_running = 1'b1;
    assign main_osc_tick = (div_q == 2'h0);
    assign flash_init_done = (init_q == 6'h3f);
    always_ff @(posedge clk) begin
        div_q <= div_q + 2'h1;
        init_q <= chip_reset_n ? 6'h00 : init_q + {5'h0, ~flash_init_done};
    end
endmodule

// ==== dv/pwr_mode_seq_tb_top.sv ====
/* Self-checking bench for the power-mode and reset sequencer.
   Assumes the oscillator and flash model stands beside the design. */
`timescale 1ns/10ps
module pwr_mode_seq_tb_top;
    localparam int IRC_START = 20;
    localparam int TK = 31;
    logic clk, resetn, rst_pin_n, wdt, por, bod_rst, bod_warn, osc_ok;
    logic fl_done, m_tick, enter, pll_req, conn_req, src_wr, src_sel;
    logic irq, cl_irq, chk_stb, sum_ok, erase, run, core_en, per_en;
    logic irc_en, irc_pwr, rtc_on, pll_on, pll_conn, cdiv, udiv, s;
    logic src_main, fl_pwr, fl_acc, reg_on, hold, crst_n, start, dbg;
    logic bod_irq, bod_stat;
    logic [1:0]  mode;
    logic [3:0]  ext_irq, wake_en, w;
    logic [11:0] ofs;
    logic [31:0] word, fetch;
    int          mismatches, check_count, waited;

    pwr_mode_seq #(.IRC_START_CYC(IRC_START)) dut_u (
        .CLK(clk), .RESETN(resetn), .RST_PIN_N(rst_pin_n), .WDT_RESET(wdt),
        .POR_ACTIVE(por), .BOD_RESET(bod_rst), .BOD_WARN(bod_warn),
        .OSC_RUNNING(osc_ok), .FLASH_INIT_DONE(fl_done), .MODE_SEL(mode),
        .MODE_ENTER(enter), .PLL_ON_REQ(pll_req), .PLL_CONN_REQ(conn_req),
        .CLK_SRC_WR(src_wr), .CLK_SRC_MAIN_SEL(src_sel),
        .MAIN_OSC_TICK(m_tick), .IRQ_PENDING(irq), .CLOCKLESS_IRQ(cl_irq),
        .EXT_IRQ(ext_irq), .EXT_WAKE_EN(wake_en), .SEC_CHECK_STB(chk_stb),
        .SEC_CHECKSUM_OK(sum_ok), .SEC_WORD_OFS(ofs), .SEC_WORD(word),
        .FULL_ERASE(erase), .CPU_RUN(run), .CORE_CLK_EN(core_en),
        .PERIPH_CLK_EN(per_en), .IRC_OUT_EN(irc_en), .IRC_POWER(irc_pwr),
        .RTC_OSC_ON(rtc_on), .PLL_ON(pll_on), .PLL_CONNECT(pll_conn),
        .CPU_DIV_CLR(cdiv), .USB_DIV_CLR(udiv), .CLK_SRC_MAIN(src_main),
        .FLASH_POWER(fl_pwr), .FLASH_ACCESS_EN(fl_acc), .LOGIC_REG_ON(reg_on),
        .PIN_HOLD(hold), .CHIP_RESET_N(crst_n), .CPU_START(start),
        .FETCH_ADDR(fetch), .BOD_IRQ(bod_irq), .BOD_STATUS(bod_stat),
        .DEBUG_EN(dbg));
    osc_flash_model part_u (.clk(clk), .chip_reset_n(crst_n),
        .osc_running(osc_ok), .flash_init_done(fl_done),
        .main_osc_tick(m_tick));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic int lo(int src);
        return src ? 4095 * 4 : 3 * TK;
    endfunction
    function automatic int hi(int src);
        return src ? 4097 * 4 + 10 : 5 * TK + 10;
    endfunction
    // Bounded wait for execution or flash access
    task automatic wait_for(input bit fl, input int lim);
        waited = 0;
        @(negedge clk);
        while ((fl ? fl_acc : run) !== 1'b1 && waited < lim) begin
            @(negedge clk);
            waited++;
        end
        check(waited < lim, 1);
    endtask
    task automatic go(input logic [1:0] m);
        @(posedge clk);
        {irq, cl_irq, ext_irq} <= 6'h0;
        mode <= m;
        @(posedge clk);
        enter <= 1'b1;
        @(posedge clk);
        enter <= 1'b0;
        @(negedge clk);
        s = cdiv & udiv;
        @(negedge clk);
        s = s | (cdiv & udiv);
    endtask
    task automatic cfg(input logic main);
        @(posedge clk);
        {pll_req, conn_req, src_wr, src_sel} <= {3'h7, main};
        @(posedge clk);
        {pll_req, conn_req, src_wr} <= 3'h0;
    endtask
    task automatic sec(input logic [31:0] v);
        @(posedge clk);
        {chk_stb, sum_ok, ofs, word} <= {2'h3, 12'h1fc, v};
        @(posedge clk);
        chk_stb <= 1'b0;
        @(negedge clk);
    endtask
    task automatic pulse_rst(input int i);
        @(posedge clk);
        {bod_rst, por, wdt, rst_pin_n} <= {3'(1 << i), i != 3};
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({crst_n, run, pll_on, src_main}, 0);
        @(posedge clk);
        {bod_rst, por, wdt, rst_pin_n} <= 4'h1;
        wait_for(0, 2000);
    endtask

    initial begin
        {resetn, wdt, por, bod_rst, bod_warn, enter, pll_req} = 7'h0;
        {conn_req, src_wr, src_sel, irq, cl_irq, chk_stb, sum_ok} = 7'h0;
        {erase, rst_pin_n, mode, ext_irq, wake_en, ofs, word} = 56'h1 << 54;
        waited = $urandom(11);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({crst_n, pll_on, src_main}, 0);
        wait_for(0, 2000);
        check(waited >= 16 * TK, 1);
        check({crst_n, start}, 2'h3);
        check(fetch, 32'h0);
        sec($urandom & 32'h7fff_ffff);
        sec(pwrseq_pkg::LOCK_WORD);
        check(dbg, 1);
        go(2'h0);
        check({run, per_en}, 1);
        repeat ($urandom_range(3, 30)) @(posedge clk);
        irq <= 1'b1;
        wait_for(0, 4);
        for (int src = 0; src < 2; src++) begin
            cfg(src[0]);
            go(2'h1);
            check({s, run, core_en, per_en, irc_en, irc_pwr, rtc_on, pll_on,
                   pll_conn, fl_pwr, hold}, 11'b10000110011);
            @(posedge clk);
            irq <= 1'b1;
            repeat (10) @(posedge clk);
            cl_irq <= 1'b1;
            check(run, 0);
            wait_for(0, 20000);
            check(waited >= lo(src) && waited <= hi(src), 1);
            check({pll_on, hold}, 0);
        end
        cfg(1'b1);
        go(2'h2);
        check({irc_pwr, fl_pwr, fl_acc, src_main, pll_on, run}, 0);
        w = 4'($urandom_range(1, 15));
        @(posedge clk);
        {wake_en, ext_irq} <= {w, ~w};
        repeat (6) @(posedge clk);
        ext_irq <= w;
        check(run, 0);
        wait_for(0, 1000);
        check(waited >= IRC_START + 3 * TK, 1);
        check(waited <= IRC_START + 5 * TK + 10, 1);
        check(fl_acc, 0);
        wait_for(1, 14000);
        check(waited >= 395 * TK && waited <= 397 * TK + 10, 1);
        go(2'h3);
        check({reg_on, run}, 0);
        @(posedge clk);
        {irq, cl_irq} <= 2'h3;
        repeat (8) @(posedge clk);
        check(run, 0);
        pulse_rst(3);
        check(reg_on, 1);
        sec(pwrseq_pkg::LOCK_WORD);
        check(dbg, 0);
        for (int i = 0; i < 4; i++) begin
            cfg(1'b1);
            pulse_rst(i);
        end
        check(dbg, 0);
        @(posedge clk);
        {erase, bod_warn} <= 2'h3;
        @(posedge clk);
        {erase, bod_warn} <= 2'h0;
        @(negedge clk);
        check({dbg, bod_irq, bod_stat}, 3'h7);
        @(negedge clk);
        check({bod_irq, bod_stat}, 0);
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule
